// >>> core/tsp_pkg.sv
// Shared constants, register map and carrier types of the slot serial port.
package tsp_pkg;

  // Register word indices on the plain register port.
  localparam logic [2:0] REG_RX_DATA      = 3'h0;
  localparam logic [2:0] REG_TX_DATA      = 3'h1;
  localparam logic [2:0] REG_CONTROL      = 3'h2;
  localparam logic [2:0] REG_SLOT_SELECT  = 3'h3;
  localparam logic [2:0] REG_ADDRESS_PAIR = 3'h4;
  localparam logic [2:0] REG_RX_STATUS    = 3'h5;

  // Control bit positions.
  localparam int unsigned CTL_RUN          = 0;
  localparam int unsigned CTL_CLOCK_SOURCE = 1;
  localparam int unsigned CTL_FRAME_SOURCE = 2;

  // Status field positions.
  localparam int unsigned STATUS_SLOT_LSB = 11;
  localparam int unsigned STATUS_LAST_LSB = 8;

  // Values after reset.
  localparam logic [2:0]  CONTROL_RESET      = 3'h0;
  localparam logic [7:0]  SLOT_SELECT_RESET  = 8'h00;
  localparam logic [15:0] ADDRESS_PAIR_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET         = 16'h0000;

  // Bit clock divider: one bit clock per four processor clocks.
  localparam logic [1:0] DIV_BEFORE_RISE = 2'h1;
  localparam logic [1:0] DIV_BEFORE_FALL = 2'h3;

  // Frame geometry in bit-clock periods.
  localparam logic [6:0] FRAME_LAST_BIT  = 7'h7f;
  localparam logic [6:0] FRAME_PRE_LAST  = 7'h7e;
  localparam logic [3:0] SLOT_LAST_BIT   = 4'hf;
  localparam logic [3:0] ADDR_LAST_BIT   = 4'h7;

  // One register port request.
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tsp_bus_type;

  // Drive of the two shared slot lines.
  typedef struct packed {
    logic data;
    logic data_oe;
    logic addr;
    logic addr_oe;
  } tsp_line_out_type;

endpackage

// >>> core/tsp_slot_port.sv
// Time-division slot serial port: timing, slot transmit and address-matched receive.
`timescale 1ns/1ps
// What this block does
// R1 - Source bit clock is processor clock over four
// R2 - Frame pulse every 128 bits, last bit
// R3 - Eight slots of sixteen data bits each
// R4 - Data MSB first, first bit half long
// R5 - Launch and sample on rising bit clock
// R6 - Transmit address LSB first, first half slot
// R7 - Address line high in last eight bits
// R8 - Address sampled only in first eight bits
// R9 - First address bit lasts half a cycle
// R10 - Unselected slots leave both lines undriven
// R11 - Sample every slot, receive on address match
// R12 - No loaded data means no drive
// R13 - Select and receive address apply at frame
// R14 - Transmit address and data apply next slot
// R15 - Transmit uses held address, no reload needed
// R16 - Current slot number readable by software
// R17 - No overrun or underflow flags
// R18 - Overwrite receive data, never halt receiving
// R19 - Partner gives one frame pulse per frame
// R20 - Misplaced frame pulse ignored, reset recovers
// R21 - AND address with receive address, nonzero matches
// R22 - Low byte receive address, high byte transmit
// R23 - Select bits enable transmit per slot
// R24 - Slot number in status bits 13 to 11
// R25 - Receive event at end of matched slot
module tsp_slot_port (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire tsp_pkg::tsp_bus_type      bus,
  output logic [15:0]                    rdata,
  input  wire logic                      serial_bit_clock_in,
  output logic                           serial_bit_clock_out,
  output logic                           serial_bit_clock_oe,
  input  wire logic                      frame_pulse_in,
  output logic                           frame_pulse_out,
  output logic                           frame_pulse_oe,
  input  wire logic                      slot_data_line_in,
  input  wire logic                      slot_address_line_in,
  output tsp_pkg::tsp_line_out_type      lines,
  output logic                           slot_receive_event
);

  // Software registers.
  logic [2:0]  control;
  logic [7:0]  slot_select_reg;
  logic [15:0] address_pair_reg;
  logic [15:0] tx_data_reg;
  logic [15:0] rx_data_reg;
  logic        tx_loaded;
  // Frame-aligned copies and status fields.
  logic [7:0]  slot_active;
  logic [7:0]  rx_addr_active;
  logic [2:0]  status_slot;
  logic [2:0]  status_last;
  logic [7:0]  status_addr;
  // Synchronisers and divider.
  logic        bclk_s1, bclk_s2, bclk_s3;
  logic        frm_s1, frm_s2, frm_s3;
  logic        dat_s1, dat_s2, dat_s3;
  logic        adr_s1, adr_s2, adr_s3;
  logic [1:0]  div;
  // Slot timing and shift state.
  logic [6:0]  bit_cnt;
  logic        locked;
  logic [15:0] rx_shift;
  logic [7:0]  addr_shift;
  logic        addr_match;
  logic        tx_act;
  logic [15:0] tx_word;
  logic [7:0]  tx_addr;
  // Combinational helpers.
  logic        run, clock_source, frame_source;
  logic        rise_evt, fall_evt;
  logic        d_smp, a_smp, frame_smp;
  logic        frame_take, slot_end, rx_done;
  logic [7:0]  next_addr;
  logic [15:0] next_word;
  logic [3:0]  next_bit;
  logic [2:0]  next_slot;

  assign run          = control[tsp_pkg::CTL_RUN];
  assign clock_source = control[tsp_pkg::CTL_CLOCK_SOURCE];
  assign frame_source = control[tsp_pkg::CTL_FRAME_SOURCE];

  // Three flip-flops on every pin input; the third stage only feeds edge detection and sampling.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      {bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
      {frm_s1, frm_s2, frm_s3}    <= 3'h0;
      {dat_s1, dat_s2, dat_s3}    <= 3'h0;
      {adr_s1, adr_s2, adr_s3}    <= 3'h0;
    end else begin
      {bclk_s1, bclk_s2, bclk_s3} <= {serial_bit_clock_in, bclk_s1, bclk_s2};
      {frm_s1, frm_s2, frm_s3}    <= {frame_pulse_in, frm_s1, frm_s2};
      {dat_s1, dat_s2, dat_s3}    <= {slot_data_line_in, dat_s1, dat_s2};
      {adr_s1, adr_s2, adr_s3}    <= {slot_address_line_in, adr_s1, adr_s2};
    end
  end

  // Divider for the bit clock when this port is the timing source.
  always_ff @(posedge clock) begin
    if (!rstn || !run || !clock_source) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1; // R1
    end
  end

  assign serial_bit_clock_out = div[1]; // R1
  assign serial_bit_clock_oe  = run & clock_source;

  // Bit clock edges and line samples. An external clock edge is seen two cycles late, so the
  // older stage is sampled to catch the value from before a partner relaunches on that edge.
  always_comb begin
    if (clock_source) begin
      rise_evt = run && (div == tsp_pkg::DIV_BEFORE_RISE);
      fall_evt = run && (div == tsp_pkg::DIV_BEFORE_FALL);
      d_smp    = dat_s2;
      a_smp    = adr_s2;
    end else begin
      rise_evt = run && bclk_s2 && !bclk_s3;
      fall_evt = run && !bclk_s2 && bclk_s3;
      d_smp    = dat_s3;
      a_smp    = adr_s3;
    end
    if (frame_source) begin
      frame_smp = frame_pulse_out;
    end else if (clock_source) begin
      frame_smp = frm_s2;
    end else begin
      frame_smp = frm_s3;
    end
  end

  // A frame is taken only to start the count or at its proper place in the frame.
  assign frame_take = rise_evt && (locked ? (frame_smp && bit_cnt == tsp_pkg::FRAME_LAST_BIT)
                                          : (frame_smp || frame_source)); // R20
  assign slot_end   = rise_evt && locked && (bit_cnt[3:0] == tsp_pkg::SLOT_LAST_BIT);
  assign next_addr  = {a_smp, addr_shift[7:1]}; // R6
  assign next_word  = {rx_shift[14:0], d_smp}; // R4
  assign rx_done    = slot_end && addr_match; // R11
  assign next_bit   = bit_cnt[3:0] + 4'h1;
  assign next_slot  = bit_cnt[6:4] + 3'h1;

  // Bit counter: 128 periods, eight slots of sixteen bits. Once locked, only a pulse at the
  // last bit is honoured; a misplaced one is ignored and only clearing run or reset recovers.
  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      bit_cnt <= 7'h00;
      locked  <= 1'b0;
    end else if (frame_take) begin
      bit_cnt <= 7'h00; // R2
      locked  <= 1'b1;
    end else if (rise_evt && locked) begin
      bit_cnt <= bit_cnt + 7'h01; // R3 R20
    end
  end

  // Frame pulse output, high during the last bit period of each frame.
  always_ff @(posedge clock) begin
    if (!rstn || !run || !frame_source) begin
      frame_pulse_out <= 1'b0;
    end else if (rise_evt) begin
      frame_pulse_out <= locked && (bit_cnt == tsp_pkg::FRAME_PRE_LAST); // R2
    end
  end

  assign frame_pulse_oe = run & frame_source;

  // Register writes. Select and receive address wait here until the frame takes them.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      control          <= tsp_pkg::CONTROL_RESET;
      slot_select_reg  <= tsp_pkg::SLOT_SELECT_RESET;
      address_pair_reg <= tsp_pkg::ADDRESS_PAIR_RESET;
      tx_data_reg      <= tsp_pkg::DATA_RESET;
    end else if (bus.wr) begin
      case (bus.addr)
        tsp_pkg::REG_CONTROL:      control          <= bus.wdata[2:0];
        tsp_pkg::REG_SLOT_SELECT:  slot_select_reg  <= bus.wdata[7:0]; // R23
        tsp_pkg::REG_ADDRESS_PAIR: address_pair_reg <= bus.wdata; // R22
        tsp_pkg::REG_TX_DATA:      tx_data_reg      <= bus.wdata;
        default:                   control          <= control;
      endcase
    end
  end

  // Loaded flag: a write in the very cycle of capture keeps the flag set for the next slot.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_loaded <= 1'b0;
    end else if (bus.wr && bus.addr == tsp_pkg::REG_TX_DATA) begin
      tx_loaded <= 1'b1;
    end else if ((slot_end || frame_take) && tx_act_next(slot_end ? next_slot : 3'h0)) begin
      tx_loaded <= 1'b0;
    end
  end

  // Transmit decision for the slot about to start.
  function automatic logic tx_act_next(input logic [2:0] slot);
    tx_act_next = slot_active[slot] && tx_loaded; // R12 R23
  endfunction

  // Frame-aligned copies of slot select and receive address.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      slot_active    <= tsp_pkg::SLOT_SELECT_RESET;
      rx_addr_active <= tsp_pkg::ADDRESS_PAIR_RESET[7:0];
    end else if (frame_take) begin
      slot_active    <= slot_select_reg; // R13
      rx_addr_active <= address_pair_reg[7:0]; // R13 R22
    end
  end

  // Slot start: capture data word and the address held now, so changes count for later slots.
  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      tx_act  <= 1'b0;
      tx_word <= tsp_pkg::DATA_RESET;
      tx_addr <= 8'h00;
    end else if (slot_end || frame_take) begin
      tx_act  <= tx_act_next(slot_end ? next_slot : 3'h0); // R10 R12
      tx_word <= tx_data_reg; // R14
      tx_addr <= address_pair_reg[15:8]; // R14 R15
    end
  end

  // Line drive. The first bit starts at the mid-slot-start falling edge, so it lasts half a
  // cycle; the rest are relaunched on each rising edge. Pins are released when not sending.
  always_ff @(posedge clock) begin
    if (!rstn || !run || !locked) begin
      lines <= '0;
    end else if (fall_evt && bit_cnt[3:0] == 4'h0) begin
      lines.data    <= tx_word[15]; // R4
      lines.addr    <= tx_addr[0]; // R6 R9
      lines.data_oe <= tx_act; // R10 R12
      lines.addr_oe <= tx_act; // R10 R12
    end else if (rise_evt && next_bit != 4'h0) begin
      lines.data <= tx_word[4'hf - next_bit]; // R4 R5
      lines.addr <= next_bit[3] ? 1'b1 : tx_addr[next_bit[2:0]]; // R6 R7
    end
  end

  // Receive shifting on every rising edge of every slot, driven or empty.
  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      rx_shift   <= tsp_pkg::DATA_RESET;
      addr_shift <= 8'h00;
      addr_match <= 1'b0;
      status_addr <= 8'h00;
    end else if (rise_evt && locked) begin
      rx_shift <= next_word; // R5 R11
      if (!bit_cnt[3]) begin
        addr_shift <= next_addr; // R8
      end
      if (bit_cnt[3:0] == tsp_pkg::ADDR_LAST_BIT) begin
        status_addr <= next_addr;
        addr_match  <= |(next_addr & rx_addr_active); // R21
      end
    end
  end

  // Completed reception overwrites the word unconditionally; there is no halt or overrun.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_data_reg        <= tsp_pkg::DATA_RESET;
      status_last        <= 3'h0;
      slot_receive_event <= 1'b0;
    end else begin
      slot_receive_event <= rx_done; // R25
      if (rx_done) begin
        rx_data_reg <= next_word; // R18
        status_last <= next_slot;
      end
    end
  end

  // Current slot number, latched as each slot starts.
  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      status_slot <= 3'h0;
    end else if (frame_take) begin
      status_slot <= 3'h0; // R24
    end else if (slot_end) begin
      status_slot <= next_slot; // R16 R24
    end
  end

  // Read data, one cycle after the strobe. No overrun or underflow bit exists anywhere.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      case (bus.addr)
        tsp_pkg::REG_RX_DATA:      rdata <= rx_data_reg;
        tsp_pkg::REG_TX_DATA:      rdata <= tx_data_reg;
        tsp_pkg::REG_CONTROL:      rdata <= {13'h0000, control}; // R17
        tsp_pkg::REG_SLOT_SELECT:  rdata <= {8'h00, slot_select_reg};
        tsp_pkg::REG_ADDRESS_PAIR: rdata <= address_pair_reg;
        tsp_pkg::REG_RX_STATUS:    rdata <= {2'h0, status_slot, status_last, status_addr}; // R16
        default:                   rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Checks kept beside the logic.
  sequence s_slot_done;
    rise_evt && locked && (bit_cnt[3:0] == 4'hf) && addr_match;
  endsequence

  sequence s_first_half_start;
    fall_evt && locked && (bit_cnt[3:0] == 4'h0);
  endsequence

  AST_DIVIDE: assert property (@(posedge clock) disable iff (!rstn) // R1
    $rose(serial_bit_clock_out) ##4 (run && clock_source) |-> $rose(serial_bit_clock_out))
    else $error("Source bit clock period is not four clocks.");

  AST_FRAME_PLACE: assert property (@(posedge clock) disable iff (!rstn) // R2
    frame_pulse_out |-> locked && bit_cnt == 7'h7f)
    else $error("Frame pulse outside the last bit period.");

  AST_ADDR_HIGH: assert property (@(posedge clock) disable iff (!rstn) // R7
    lines.addr_oe && bit_cnt[3] |-> lines.addr)
    else $error("Address line low in second half of slot.");

  AST_NO_DRIVE: assert property (@(posedge clock) disable iff (!rstn) // R10
    s_first_half_start and !tx_act |=> !lines.data_oe && !lines.addr_oe)
    else $error("Lines driven in a slot not transmitted.");

  AST_TX_FIRST: assert property (@(posedge clock) disable iff (!rstn) // R6
    s_first_half_start and tx_act |=> lines.addr_oe && lines.addr == tx_addr[0]
      && lines.data == tx_word[15])
    else $error("First slot bits not launched from captured word.");

  AST_RX_WRITE: assert property (@(posedge clock) disable iff (!rstn) // R18
    s_slot_done |=> slot_receive_event && rx_data_reg == $past(next_word))
    else $error("Matched slot did not overwrite received word.");

  AST_RX_CAUSE: assert property (@(posedge clock) disable iff (!rstn) // R25
    slot_receive_event |-> $past(rx_done))
    else $error("Receive event without a matched slot.");

  AST_MISPLACED: assert property (@(posedge clock) disable iff (!rstn) // R20
    rise_evt && locked && frame_smp && bit_cnt != 7'h7f |=> bit_cnt == 7'($past(bit_cnt) + 7'h01))
    else $error("Misplaced frame pulse moved the slot count.");

  AST_SLOT_STATUS: assert property (@(posedge clock) disable iff (!rstn) // R24
    locked |-> status_slot == bit_cnt[6:4])
    else $error("Slot status differs from current slot.");

  AST_SELECT_FRAME: assert property (@(posedge clock) disable iff (!rstn) // R13
    $changed(slot_active) |-> $past(frame_take))
    else $error("Slot select applied away from a frame pulse.");

  // Slot start gating, the held transmit address, receive shifting and the ignored address half.
  AST_LOAD_GATE: assert property (@(posedge clock) disable iff (!rstn) // R12
    (slot_end || frame_take) && !tx_loaded |=> !tx_act)
    else $error("Slot started sending with no loaded word.");

  AST_ADDR_HELD: assert property (@(posedge clock) disable iff (!rstn) // R15
    slot_end || frame_take |=> tx_addr == $past(address_pair_reg[15:8]))
    else $error("Slot did not take the held transmit address.");

  AST_RX_SAMPLE: assert property (@(posedge clock) disable iff (!rstn) // R11
    rise_evt && locked |=> rx_shift == $past(next_word))
    else $error("Line sample not shifted in on a rising edge.");

  AST_ADDR_WINDOW: assert property (@(posedge clock) disable iff (!rstn) // R8
    rise_evt && locked && bit_cnt[3] |=> addr_shift == $past(addr_shift))
    else $error("Address line sampled in the second half of a slot.");

endmodule

// >>> verification/tsp_far_end.sv
// Far-end model of the shared slot bus: frame timing, one talker slot and a listener.
`timescale 1ns/1ps
module tsp_far_end (
  input  wire logic                      bclk,
  input  wire logic                      misplace,
  input  wire logic                      tx_en,
  input  wire logic [7:0]                tx_addr,
  input  wire logic [15:0]               tx_word,
  input  wire logic [2:0]                cap_slot,
  input  wire tsp_pkg::tsp_line_out_type dev,
  output logic                           frame,
  output logic                           data_wire,
  output logic                           addr_wire,
  output logic [6:0]                     k,
  output logic [15:0]                    cap_word,
  output logic [7:0]                     cap_addr,
  output logic                           cap_high
);
  localparam logic [2:0] TX_SLOT = 3'h2;
  logic        drv = 1'b0;
  logic        pdata = 1'b0;
  logic        paddr = 1'b0;
  logic        flt = 1'b0;
  logic        hi = 1'b1;
  logic [3:0]  nb;
  logic [15:0] sh = 16'h0000;
  logic [7:0]  ash = 8'h00;
  initial k = 7'h00;
  initial frame = 1'b0;

  // The address line has a pull-down; a released data line keeps changing.
  assign addr_wire = dev.addr_oe ? dev.addr : (drv ? paddr : 1'b0);
  assign data_wire = dev.data_oe ? dev.data : (drv ? pdata : flt);
  assign nb = k[3:0] + 4'h1;

  // Frame pulse covers period 127; the first bit of a slot starts at the falling edge.
  always @(negedge bclk) begin
    frame <= (k == 7'h7f) || (misplace && k == 7'h3c);
    flt <= ~flt;
    if (k[3:0] == 4'h0) begin
      drv <= tx_en && (k[6:4] == TX_SLOT);
      pdata <= tx_word[15];
      paddr <= tx_addr[0];
    end
  end

  // Later bits launch on the rising edge; a small output delay gives listeners hold.
  always @(posedge bclk) begin
    k <= k + 7'h01;
    if (k[3:0] != 4'hf) begin
      pdata <= #20 tx_word[4'hf - nb];
      paddr <= #20 (nb < 4'h8) ? tx_addr[nb[2:0]] : 1'b1;
    end
  end

  // The listener samples each bit on the rising edge that ends it.
  always @(posedge bclk) begin
    if (k[6:4] == cap_slot) begin
      sh <= {sh[14:0], data_wire};
      if (k[3] == 1'b0) begin
        ash <= {addr_wire, ash[7:1]};
      end
      hi <= (k[3] == 1'b0) ? 1'b1 : (hi & addr_wire);
      if (k[3:0] == 4'hf) begin
        cap_word <= {sh[14:0], data_wire};
        cap_addr <= ash;
        cap_high <= hi & addr_wire;
      end
    end
  end
endmodule

// >>> verification/tsp_slot_port_tb.sv
// Self-checking bench of the slot serial port against the far-end model.
`timescale 1ns/1ps
module tsp_slot_port_tb;
  logic                      clock = 1'b0;
  logic                      rstn = 1'b0;
  logic                      bclk = 1'b0;
  tsp_pkg::tsp_bus_type      bus = '0;
  tsp_pkg::tsp_line_out_type lines;
  logic [15:0]               rdata, d, tx_word = 16'h1234, cap_word;
  logic                      sbc_out, sbc_oe, fp_out, fp_oe, frame, data_wire, addr_wire;
  logic                      rx_event, cap_high, p1, p2, misplace = 1'b0, tx_en = 1'b0;
  logic [7:0]                tx_addr = 8'h06, cap_addr;
  logic [2:0]                cap_slot = 3'h0;
  logic [6:0]                k;
  int                        fail_count = 0, num_checks = 0, ev_cnt = 0, oe_cnt = 0;
  int                        stray_cnt = 0, e0, o0, n1, n2, nh;

  always #5 clock = ~clock;

  // The link clock runs free, sixteen clocks per period, each edge 2 ns after a rising clock edge.
  initial begin
    #37;
    forever #80 bclk = ~bclk;
  end

  tsp_slot_port u_tsp_slot_port (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
    .serial_bit_clock_in(bclk), .serial_bit_clock_out(sbc_out), .serial_bit_clock_oe(sbc_oe),
    .frame_pulse_in(frame), .frame_pulse_out(fp_out), .frame_pulse_oe(fp_oe),
    .slot_data_line_in(data_wire), .slot_address_line_in(addr_wire), .lines(lines),
    .slot_receive_event(rx_event));

  tsp_far_end u_tsp_far_end (.bclk(bclk), .misplace(misplace), .tx_en(tx_en),
    .tx_addr(tx_addr), .tx_word(tx_word), .cap_slot(cap_slot), .dev(lines), .frame(frame),
    .data_wire(data_wire), .addr_wire(addr_wire), .k(k), .cap_word(cap_word),
    .cap_addr(cap_addr), .cap_high(cap_high));

  // Tallies of receive events, drive cycles and drives outside the listened slot.
  always @(posedge clock) begin
    if (rx_event === 1'b1) ev_cnt <= ev_cnt + 1;
    if (lines.data_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if ((lines.data_oe | lines.addr_oe) === 1'b1 && k[6:4] != cap_slot && k[3:0] > 4'h1 &&
        k[3:0] < 4'hf) stray_cnt <= stray_cnt + 1;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each access waits for a fresh edge so no strobe is assigned twice in one step.
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    v = rdata;
  endtask

  task automatic rc(input string w, input logic [2:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(w, v, exp);
  endtask

  // Waits for the far end to enter bit period n, bounded by a little over two frames.
  task automatic wait_k(input logic [6:0] n);
    int i;
    i = 0;
    while (k === n && i < 40) begin
      @(posedge clock);
      i++;
    end
    while (k !== n && i < 4200) begin
      @(posedge clock);
      i++;
    end
  endtask

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests take about a dozen frames of 2048 clocks; this cuts a hang short.
  initial begin
    #900000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rc("reset value", a[2:0], 16'h0000);
    @(posedge clock);
    #1;
    check("idle read data", rdata, 16'h0000);
    done("reset");
    wr(tsp_pkg::REG_SLOT_SELECT, 16'h0081);
    wr(tsp_pkg::REG_ADDRESS_PAIR, 16'h5a03);
    wr(tsp_pkg::REG_CONTROL, 16'h0001);
    rc("slot select", tsp_pkg::REG_SLOT_SELECT, 16'h0081);
    rc("address pair", tsp_pkg::REG_ADDRESS_PAIR, 16'h5a03);
    rc("no flag bits", tsp_pkg::REG_CONTROL, 16'h0001);
    wait_k(7'h78);
    wait_k(7'h78);
    o0 = oe_cnt;
    wait_k(7'h78);
    check("drive without load", 16'(oe_cnt - o0), 16'h0000);
    wr(tsp_pkg::REG_TX_DATA, 16'ha5c3);
    wait_k(7'h11);
    check("sent word", cap_word, 16'ha5c3);
    check("sent address", {8'h00, cap_addr}, 16'h005a);
    check("address high half", {15'h0000, cap_high}, 16'h0001);
    wait_k(7'h78);
    wr(tsp_pkg::REG_TX_DATA, 16'h3c5a);
    wait_k(7'h11);
    check("second word", cap_word, 16'h3c5a);
    check("address kept", {8'h00, cap_addr}, 16'h005a);
    cap_slot <= 3'h7;
    wait_k(7'h40);
    wr(tsp_pkg::REG_TX_DATA, 16'h0ff0);
    wr(tsp_pkg::REG_ADDRESS_PAIR, 16'h3c03);
    wait_k(7'h01);
    check("same frame word", cap_word, 16'h0ff0);
    check("same frame address", {8'h00, cap_addr}, 16'h003c);
    check("stray drive", 16'(stray_cnt), 16'h0000);
    done("transmit");
    tx_en <= 1'b1;
    e0 = ev_cnt;
    wait_k(7'h32);
    check("match event", 16'(ev_cnt - e0), 16'h0001);
    rc("received word", tsp_pkg::REG_RX_DATA, 16'h1234);
    wait_k(7'h38);
    repeat (8) @(posedge clock);
    rd(tsp_pkg::REG_RX_STATUS, d);
    check("current slot", {13'h0000, d[13:11]}, 16'h0003);
    check("last slot and address", {5'h00, d[10:0]}, 16'h0300);
    tx_word <= 16'h4321;
    wait_k(7'h32);
    rc("overwritten word", tsp_pkg::REG_RX_DATA, 16'h4321);
    tx_addr <= 8'h08;
    tx_word <= 16'h5555;
    e0 = ev_cnt;
    wait_k(7'h32);
    rc("unmatched slot", tsp_pkg::REG_RX_DATA, 16'h4321);
    tx_addr <= 8'h04;
    wait_k(7'h14);
    wr(tsp_pkg::REG_ADDRESS_PAIR, 16'h3c04);
    wait_k(7'h32);
    check("receive address deferred", 16'(ev_cnt - e0), 16'h0000);
    wait_k(7'h32);
    check("receive address applied", 16'(ev_cnt - e0), 16'h0001);
    done("receive");
    misplace <= 1'b1;
    tx_word <= 16'h6666;
    wait_k(7'h46);
    misplace <= 1'b0;
    wait_k(7'h32);
    rc("after misplaced pulse", tsp_pkg::REG_RX_DATA, 16'h6666);
    wr(tsp_pkg::REG_CONTROL, 16'h0000);
    wr(tsp_pkg::REG_CONTROL, 16'h0001);
    tx_word <= 16'h7777;
    wait_k(7'h32);
    rc("after restart", tsp_pkg::REG_RX_DATA, 16'h7777);
    done("misplaced frame");
    wr(tsp_pkg::REG_CONTROL, 16'h0007);
    repeat (600) @(posedge clock);
    #1;
    check("clock drive enable", {15'h0000, sbc_oe}, 16'h0001);
    check("frame drive enable", {15'h0000, fp_oe}, 16'h0001);
    n1 = 0;
    n2 = 0;
    nh = 0;
    p1 = sbc_out;
    p2 = fp_out;
    // A 1024-clock window holds exactly 256 bit clocks and two whole frame pulses.
    repeat (1024) begin
      @(posedge clock);
      #1;
      if (sbc_out === 1'b1 && p1 === 1'b0) n1++;
      if (fp_out === 1'b1 && p2 === 1'b0) n2++;
      if (fp_out === 1'b1) nh++;
      p1 = sbc_out;
      p2 = fp_out;
    end
    check("bit clock edges", 16'(n1), 16'h0100);
    check("frame pulses", 16'(n2), 16'h0002);
    check("frame pulse length", 16'(nh), 16'h0008);
    done("timing source");
    conclude();
  end
endmodule
